// ==== fault_srq_pkg.sv ====
// constants, field layouts and request carrier for the fault latch and service request block
package fault_srq_pkg;
    // live condition bit positions, shared by condition, enable and latch bytes
    localparam int COND_CONST_VOLT = 0;
    localparam int COND_POS_CURRENT = 1;
    localparam int COND_NEG_CURRENT = 2;
    localparam int COND_OVERVOLT = 3;
    localparam int COND_OVERTEMP = 4;
    localparam int COND_UNREGULATED = 5;
    localparam int COND_OVERCURRENT = 6;
    localparam int COND_COUPLED = 7;
    // regulation mode bits hidden while reprogramming delay runs
    localparam logic [7:0] REG_MODE_BITS = 8'h27;

    // poll summary byte layout
    localparam int POLL_POWERUP = 7;
    localparam int POLL_RQS = 6;
    localparam int POLL_ERROR = 5;
    localparam int POLL_READY = 4;
    localparam int POLL_FAULT_LO = 0;

    // service request enable codes
    localparam logic [1:0] SRQ_OFF = 2'h0;
    localparam logic [1:0] SRQ_FAULT = 2'h1;
    localparam logic [1:0] SRQ_ERROR = 2'h2;
    localparam logic [1:0] SRQ_BOTH = 2'h3;

    // values after reset
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [1:0] SRQ_CODE_RESET = SRQ_OFF;
    localparam logic POWERUP_RESET = 1'b1;

    // reprogramming delay timing
    localparam int CLK_HZ = 40_000_000;
    localparam int DLY_STEP_US = 4000;
    localparam int DLY_STEP_CYCLES = (CLK_HZ / 1_000_000) * DLY_STEP_US;
    localparam int DLY_DEFAULT_MS = 20;
    localparam int DLY_MAX_S = 32;
    localparam int DLY_STEP_W = 13;
    localparam logic [12:0] DLY_DEFAULT_STEPS = 13'((DLY_DEFAULT_MS * 1000) / DLY_STEP_US);
    localparam logic [12:0] DLY_MAX_STEPS = 13'((DLY_MAX_S * 1_000_000) / DLY_STEP_US);

    // one host command, taken in the cycle that any strobe is high
    typedef struct packed {
        logic enable_wr;  // write enable byte of chan
        logic enable_rd;  // query enable byte of chan
        logic latch_rd;   // read and clear latch of chan
        logic poll;       // serial poll
        logic err_query;  // error query
        logic clear_cmd;  // clear command
        logic srq_wr;     // write srq enable code
        logic srq_rd;     // query srq enable code
        logic pon_wr;     // write power-on srq enable
        logic pon_rd;     // query power-on srq enable
        logic dly_wr;     // write reprogramming delay steps of chan
        logic reprog;     // regulation command executed on chan
        logic [1:0] chan; // output index, 0 for output 1
        logic [15:0] data; // write data
    } host_req_t;
endpackage

// ==== fault_latch_service_request.sv ====
// per-output fault latching, poll summary and service request generation
`timescale 1ns/1ps

// limitations of this block
// - error codes, accumulated status and command parsing live elsewhere
// - the reprogramming delay counts whole steps of STEP_CYCLES clocks;
//   rounding a host value to the nearest step is left to the parser
// - a zero delay hides nothing and re-raises applicable mode bits at once
// - only one read strobe per cycle is expected; see the answer mux
// - req, cmd_busy and err_event come from logic on clk_sys and are not
//   synchronised; cond_pins and line_dropout pass two flops each
// - pon_en_nv is read in the first cycle after reset release only
// - a second reset in mid-run counts as a fresh power-on event
// - outputs at or beyond NUM_OUT read as zero everywhere
module fault_latch_service_request #(
    parameter int NUM_OUT = 4,
    parameter int STEP_CYCLES = fault_srq_pkg::DLY_STEP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [31:0] cond_pins,
    input wire logic line_dropout,
    input wire fault_srq_pkg::host_req_t req,
    input wire logic cmd_busy,
    input wire logic err_event,
    input wire logic pon_en_nv,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic srq_line,
    output logic srq_lamp,
    output logic pon_en_store,
    output logic pon_en_store_wr
);
    // elaboration check on the number of outputs
    // the poll byte holds four fault flags, so at most four outputs;
    // a single-output unit would leave three flags with no meaning
    if (NUM_OUT < 2 || NUM_OUT > 4) begin : g_bad_num_out
        $error("NUM_OUT must lie between 2 and 4");
    end
    // step length in clock cycles; zero would make every delay vanish
    if (STEP_CYCLES < 1) begin : g_bad_step
        $error("STEP_CYCLES must be at least 1");
    end

    // channel hit: strobe aimed at a given output
    // strobes for outputs beyond NUM_OUT only reach the absent branch,
    // so writes aimed there fall away and reads aimed there answer zero
    function automatic logic chan_hit(input logic strobe, input logic [1:0] chan, input int idx);
        chan_hit = strobe && (int'(chan) == idx);
    endfunction

    // arrays are sized for four outputs whatever NUM_OUT is; the
    // absent entries are held at zero so that reads stay defined
    // per-output state
    logic [7:0] cond_s1_q [4];   // first synchroniser stage
    logic [7:0] cond_s2_q [4];   // synchronised condition
    logic [7:0] eff_prev_q [4];  // previous visible condition
    logic [7:0] enable_q [4];    // host enable byte
    logic [7:0] enable_prev_q [4]; // previous enable byte
    logic [7:0] latch_q [4];     // latched faults
    logic [12:0] dly_steps_q [4]; // programmed delay in steps
    logic [31:0] dly_cnt_q [4];  // remaining delay cycles
    logic [3:0] fault_flag;      // nonzero latch per output

    // shared state
    // dropout pin path
    logic drop_s1_q;             // dropout synchroniser stage 1
    logic drop_s2_q;             // dropout synchronised
    logic drop_prev_q;           // dropout edge memory
    logic start_q;               // one after reset release
    logic pon_en_q;              // power-on srq enable copy
    logic powerup_q;             // powerup flag
    logic rqs_q;                 // request service flag
    logic err_q;                 // error flag
    logic ready_q;               // ready flag
    logic [1:0] srq_code_q;      // srq enable code
    logic [3:0] fault_flag_prev_q; // for new-fault detection
    // registered outputs
    logic [7:0] rd_data_q;       // last query answer
    logic rd_valid_q;            // answer strobe
    logic pon_store_q;           // value toward non-volatile store
    logic pon_store_wr_q;        // write pulse toward the store

    // per-output slice: visible condition, edge detection, latch and delay
    // the latch looks at two kinds of change, one cycle apart each:
    //  - a visible condition bit rising while its enable bit is set
    //  - an enable bit rising while its condition bit is already set
    // a clearing read and a new set in the same cycle keep the set bit,
    // so no fault is lost between the host's read and the next poll
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_out
            // visible condition: regulation bits hidden during delay
            wire logic dly_run = dly_cnt_q[gi] != 32'h0000_0000;
            wire logic [7:0] hide = dly_run ? fault_srq_pkg::REG_MODE_BITS : 8'h00;
            wire logic [7:0] eff = cond_s2_q[gi] & ~hide;
            // new edges of condition or enable
            wire logic [7:0] rise = eff & ~eff_prev_q[gi] & enable_q[gi];
            wire logic [7:0] unmask = eff & enable_q[gi] & ~enable_prev_q[gi];
            // strobes decoded for this output
            wire logic clr = chan_hit(req.latch_rd, req.chan, gi);
            wire logic ewr = chan_hit(req.enable_wr, req.chan, gi);
            wire logic dwr = chan_hit(req.dly_wr, req.chan, gi) &&
                (req.data[12:0] <= fault_srq_pkg::DLY_MAX_STEPS);
            wire logic rpg = chan_hit(req.reprog, req.chan, gi);
            wire logic [31:0] dly_load = 32'(dly_steps_q[gi]) * 32'(STEP_CYCLES);
            // a regulation command with a zero delay hides nothing, so the
            // applicable mode bits are raised straight away instead
            wire logic rpg_now = rpg && (dly_steps_q[gi] == 13'h0);
            wire logic [7:0] reraise = rpg_now ?
                (eff & enable_q[gi] & fault_srq_pkg::REG_MODE_BITS) : 8'h00;
            wire logic [7:0] set_bits = rise | unmask | reraise;
            // set wins over clearing read; bits held until read
            wire logic [7:0] latch_d = (clr ? 8'h00 : latch_q[gi]) | set_bits;
            // delay counter: load on command, count down to zero, then rest
            wire logic [31:0] cnt_d = rpg ? dly_load :
                (dly_run ? dly_cnt_q[gi] - 32'h0000_0001 : dly_cnt_q[gi]);

            // live branch carries state; absent branch ties it to zero
            // output present only up to NUM_OUT
            if (gi < NUM_OUT) begin : g_live
                assign fault_flag[gi] = |latch_q[gi];
                // condition synchroniser, latch and delay counter
                // only the second stage feeds logic: the first may be
                // metastable, the pins change with no regard to clk_sys
                always_ff @(posedge clk_sys or negedge nrst) begin
                    if (!nrst) begin
                        cond_s1_q[gi] <= 8'h00;
                        cond_s2_q[gi] <= 8'h00;
                        eff_prev_q[gi] <= 8'h00;
                        latch_q[gi] <= fault_srq_pkg::LATCH_RESET;
                        dly_cnt_q[gi] <= 32'h0000_0000;
                    end else begin
                        cond_s1_q[gi] <= cond_pins[gi*8 +: 8];
                        cond_s2_q[gi] <= cond_s1_q[gi];
                        eff_prev_q[gi] <= eff;
                        latch_q[gi] <= latch_d;
                        dly_cnt_q[gi] <= cnt_d;
                    end
                end
                // host-owned enable byte and delay setting
                // the device side never writes enable_q; only ewr moves it
                // delay settings above the longest legal value are refused
                always_ff @(posedge clk_sys or negedge nrst) begin
                    if (!nrst) begin
                        enable_q[gi] <= fault_srq_pkg::ENABLE_RESET;
                        enable_prev_q[gi] <= fault_srq_pkg::ENABLE_RESET;
                        dly_steps_q[gi] <= fault_srq_pkg::DLY_DEFAULT_STEPS;
                    end else begin
                        enable_prev_q[gi] <= enable_q[gi];
                        if (ewr) begin
                            enable_q[gi] <= req.data[7:0];
                        end
                        if (dwr) begin
                            dly_steps_q[gi] <= req.data[12:0];
                        end
                    end
                end
            end else begin : g_absent
                // absent output: tied state, flag always zero
                // kept as flops so every array entry has one clocked driver
                assign fault_flag[gi] = 1'b0;
                always_ff @(posedge clk_sys or negedge nrst) begin
                    if (!nrst) begin
                        cond_s1_q[gi] <= 8'h00;
                        cond_s2_q[gi] <= 8'h00;
                        eff_prev_q[gi] <= 8'h00;
                        latch_q[gi] <= 8'h00;
                        dly_cnt_q[gi] <= 32'h0000_0000;
                        enable_q[gi] <= 8'h00;
                        enable_prev_q[gi] <= 8'h00;
                        dly_steps_q[gi] <= 13'h0;
                    end else begin
                        cond_s1_q[gi] <= 8'h00;
                        cond_s2_q[gi] <= 8'h00;
                        eff_prev_q[gi] <= 8'h00;
                        latch_q[gi] <= 8'h00;
                        dly_cnt_q[gi] <= 32'h0000_0000;
                        enable_q[gi] <= 8'h00;
                        enable_prev_q[gi] <= 8'h00;
                        dly_steps_q[gi] <= 13'h0;
                    end
                end
            end
        end
    endgenerate

    // start_q stands for power-on: one for the first cycle after release;
    // a line dropout is handled the same way and also sets powerup flag
    // power events: first cycle after reset release, or dropout edge
    wire logic drop_rise = drop_s2_q && !drop_prev_q;
    wire logic power_event = start_q || drop_rise;
    // enable copy: strap caught at release, host writes update it
    wire logic pon_en_now = start_q ? pon_en_nv : pon_en_q;

    // a request is raised on the rising edge of a cause only; a flag that
    // stays set would otherwise raise rqs again straight after each poll
    // and the controller could never see the line drop
    // new qualifying events; held flags do not retrigger
    wire logic new_fault = |(fault_flag & ~fault_flag_prev_q);
    wire logic fault_req = new_fault && srq_code_q[0];
    wire logic err_req = err_event && !err_q && srq_code_q[1];
    wire logic pon_req = power_event && pon_en_now;
    wire logic srq_event = fault_req || err_req || pon_req;

    // flags share one rule: the setting event of a cycle beats
    // the clearing strobe of the same cycle, so no event is lost
    // flags: set beats clear in the same cycle
    wire logic rqs_d = srq_event || (rqs_q && !req.poll);
    wire logic err_d = err_event || (err_q && !req.err_query);
    wire logic powerup_d = power_event || (powerup_q && !req.clear_cmd);

    // poll summary byte
    // fault flags of absent outputs are tied to zero above
    wire logic [7:0] poll_byte = {
        powerup_q,  // bit 7
        rqs_q,      // bit 6
        err_q,      // bit 5
        ready_q,    // bit 4
        fault_flag  // bits 3 to 0, output 4 down to 1
    };

    // only one read strobe is expected at a time; if several come together,
    // enable byte beats latch, latch beats poll, poll beats the code queries
    // rd_data keeps the last answer until the next read strobe
    // query answer selection
    wire logic [7:0] rd_sel =
        req.enable_rd ? enable_q[req.chan] :
        req.latch_rd ? latch_q[req.chan] :
        req.poll ? poll_byte :
        req.srq_rd ? {6'h00, srq_code_q} :
        req.pon_rd ? {7'h00, pon_en_now} : 8'h00;
    // any read strobe except err_query produces one answer strobe
    wire logic rd_any =
        req.enable_rd ||
        req.latch_rd ||
        req.poll ||
        req.srq_rd ||
        req.pon_rd;

    // power event detection and synchroniser for dropout pin
    // drop_prev_q reads the second stage only, so the edge is clean;
    // start_q resets to one so release itself is seen as power-on
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            drop_s1_q <= 1'b0;
            drop_s2_q <= 1'b0;
            drop_prev_q <= 1'b0;
            start_q <= 1'b1;
        end else begin
            drop_s1_q <= line_dropout;
            drop_s2_q <= drop_s1_q;
            drop_prev_q <= drop_s2_q;
            start_q <= 1'b0;
        end
    end

    // poll summary flags and fault edge memory
    // ready follows the inverse of cmd_busy one cycle late and reads zero in reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            powerup_q <= fault_srq_pkg::POWERUP_RESET;
            rqs_q <= 1'b0;
            err_q <= 1'b0;
            ready_q <= 1'b0;
            fault_flag_prev_q <= 4'h0;
        end else begin
            powerup_q <= powerup_d;
            rqs_q <= rqs_d;
            err_q <= err_d;
            ready_q <= !cmd_busy;
            fault_flag_prev_q <= fault_flag;
        end
    end

    // srq code and power-on enable settings
    // pon_wr sets the working copy at once and pulses a write toward the
    // non-volatile store; the store's own value is read only at release
    // every two-bit srq code is meaningful, so none is refused
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            srq_code_q <= fault_srq_pkg::SRQ_CODE_RESET;
            pon_en_q <= 1'b0;
            pon_store_q <= 1'b0;
            pon_store_wr_q <= 1'b0;
        end else begin
            if (req.srq_wr) begin
                srq_code_q <= req.data[1:0];
            end
            pon_en_q <= req.pon_wr ? req.data[0] : pon_en_now;
            pon_store_q <= req.pon_wr ? req.data[0] : pon_store_q;
            pon_store_wr_q <= req.pon_wr;
        end
    end

    // registered query answer, one cycle after the taking edge
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q <= rd_any ? rd_sel : rd_data_q;
            rd_valid_q <= rd_any;
        end
    end

    // outputs straight from flops; bus line and lamp follow rqs
    // the lamp and the bus line cannot differ, both being rqs_q
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign srq_line = rqs_q;
    assign srq_lamp = rqs_q;
    assign pon_en_store = pon_store_q;
    assign pon_en_store_wr = pon_store_wr_q;
endmodule

// ==== fault_srq_assertions.sv ====
// checker watching the fault latch block ports
`timescale 1ns/1ps
module fault_srq_assertions #(
    parameter int NUM_OUT = 4
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire fault_srq_pkg::host_req_t req,
    input wire logic cmd_busy,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic srq_line,
    input wire logic srq_lamp,
    input wire logic pon_en_store,
    input wire logic pon_en_store_wr
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // poll that wins the read mux
    wire logic poll_top = req.poll && !req.enable_rd && !req.latch_rd;
    wire logic code_top = req.srq_rd && !req.poll && !req.enable_rd && !req.latch_rd;
    wire logic pon_bit = req.data[0];
    // clear command, one idle cycle, then a poll
    sequence clr_then_poll;
        req.clear_cmd ##2 poll_top;
    endsequence
    poll_answer_a: assert property (req.poll |=> rd_valid)
        else $error("poll not answered");
    poll_rqs_a: assert property (poll_top |=> rd_data[6] == $past(srq_line))
        else $error("poll byte request bit wrong");
    srq_fall_a: assert property ($fell(srq_line) |-> $past(req.poll))
        else $error("request dropped without poll");
    absent_flags_a: assert property (poll_top |=> (rd_data[3:0] >> NUM_OUT) == 4'h0)
        else $error("absent output flag set");
    code_width_a: assert property (code_top |=> rd_data[7:2] == 6'h00)
        else $error("request code query too wide");
    lamp_line_a: assert property (srq_lamp == srq_line)
        else $error("lamp differs from bus line");
    pon_store_a: assert property (req.pon_wr |=> pon_en_store_wr && pon_en_store == $past(pon_bit))
        else $error("power-on enable not stored");
    ready_bit_a: assert property (poll_top && $stable(cmd_busy) && $past(nrst, 2)
        |=> rd_data[4] == !$past(cmd_busy))
        else $error("ready bit wrong");
    pon_clear_a: assert property (clr_then_poll |=> !rd_data[7])
        else $error("power-up flag not cleared");
endmodule
bind fault_latch_service_request fault_srq_assertions #(.NUM_OUT(NUM_OUT)) chk (
    .clk_sys(clk_sys), .nrst(nrst), .req(req), .cmd_busy(cmd_busy), .rd_data(rd_data),
    .rd_valid(rd_valid), .srq_line(srq_line), .srq_lamp(srq_lamp),
    .pon_en_store(pon_en_store), .pon_en_store_wr(pon_en_store_wr));

// ==== bus_ctrl_model.sv ====
// bus controller model issuing queries, commands and serial polls
`timescale 1ns/1ps
module bus_ctrl_model (
    input wire logic clk_sys,
    input wire logic [7:0] rd_data,
    output fault_srq_pkg::host_req_t req
);
    initial req = '0;
    // one-cycle strobe, changed only at falling edges
    task automatic send(input logic [11:0] s, input logic [1:0] ch, input logic [15:0] d);
        @(negedge clk_sys);
        req = fault_srq_pkg::host_req_t'({s, ch, d});
        @(negedge clk_sys);
        req = '0;
    endtask
    // answer lands one cycle after the taking edge
    task automatic query(input logic [11:0] s, input logic [1:0] ch, output logic [7:0] d);
        send(s, ch, 16'h0000);
        d = rd_data;
    endtask
    // serial poll, then read the first flagged latch
    task automatic service(output logic [7:0] pb, output logic [7:0] lv);
        int ch;
        query(12'h100, 2'h0, pb);
        ch = 0;
        while (ch < 3 && !pb[ch]) ch++;
        query(12'h200, 2'(ch), lv);
    endtask
endmodule

// ==== fault_latch_service_request_tb_top.sv ====
// self-checking bench for the fault latch and service request block
`timescale 1ns/1ps
module fault_latch_service_request_tb_top;
    localparam logic [11:0] EWR = 12'h800, ERD = 12'h400, LRD = 12'h200, POLL = 12'h100;
    localparam logic [11:0] EQ = 12'h080, CLR = 12'h040, SWR = 12'h020, SRD = 12'h010;
    localparam logic [11:0] PWR = 12'h008, REP = 12'h001;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] cond_pins = 32'h0;
    logic line_dropout = 1'b0, cmd_busy = 1'b0, err_event = 1'b0, pon_en_nv = 1'b1;
    logic [7:0] rd_data, d, lv;
    logic rd_valid, srq_line, srq_lamp;
    fault_srq_pkg::host_req_t req;
    int fails = 0;
    int checks_done = 0;
    always #12.5 clk_sys = ~clk_sys;
    fault_latch_service_request #(.NUM_OUT(3), .STEP_CYCLES(4)) dut (
        .clk_sys(clk_sys), .nrst(nrst), .cond_pins(cond_pins), .line_dropout(line_dropout),
        .req(req), .cmd_busy(cmd_busy), .err_event(err_event), .pon_en_nv(pon_en_nv),
        .rd_data(rd_data), .rd_valid(rd_valid), .srq_line(srq_line), .srq_lamp(srq_lamp),
        .pon_en_store(), .pon_en_store_wr());
    bus_ctrl_model host (.clk_sys(clk_sys), .rd_data(rd_data), .req(req));
    task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", w, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic poll_is(input string w, input logic [7:0] e);
        host.query(POLL, 2'h0, d);
        check(w, d, e);
    endtask
    task automatic latch_is(input logic [1:0] ch, input string w, input logic [7:0] e);
        host.query(LRD, ch, d);
        check(w, d, e);
    endtask
    task automatic err_pulse();
        err_event = 1'b1;
        idle(1);
        err_event = 1'b0;
        idle(3);
    endtask
    task automatic t_powerup();
        idle(3);
        check("srq at power-up", {7'h0, srq_line}, 8'h01);
        poll_is("poll at power-up", 8'hd0);
        check("srq after poll", {7'h0, srq_line}, 8'h00);
        host.send(CLR, 2'h0, 16'h0000);
        poll_is("poll after clear", 8'h10);
        $display("power-up test done");
    endtask
    task automatic t_latch();
        host.send(EWR, 2'h1, 16'h0008);
        host.query(ERD, 2'h1, d);
        check("enable readback", d, 8'h08);
        cond_pins[11] = 1'b1;
        idle(5);
        poll_is("fault flag", 8'h12);
        cond_pins[11] = 1'b0;
        idle(5);
        latch_is(2'h1, "latch kept", 8'h08);
        latch_is(2'h1, "latch cleared", 8'h00);
        poll_is("flag cleared", 8'h10);
        $display("latch test done");
    endtask
    task automatic t_mask_edge();
        cond_pins[4] = 1'b1;
        idle(5);
        latch_is(2'h0, "masked cond", 8'h00);
        host.send(EWR, 2'h0, 16'h0010);
        idle(2);
        latch_is(2'h0, "newly enabled", 8'h10);
        latch_is(2'h0, "no relatch", 8'h00);
        cond_pins[4] = 1'b0;
        $display("enable edge test done");
    endtask
    task automatic t_reprog();
        host.send(EWR, 2'h0, 16'h0001);
        cond_pins[0] = 1'b1;
        idle(5);
        latch_is(2'h0, "cv latched", 8'h01);
        host.send(REP, 2'h0, 16'h0000);
        cond_pins[0] = 1'b0;
        idle(4);
        cond_pins[0] = 1'b1;
        idle(4);
        latch_is(2'h0, "cv hidden", 8'h00);
        idle(25);
        latch_is(2'h0, "cv reraised", 8'h01);
        cond_pins[0] = 1'b0;
        $display("reprogramming test done");
    endtask
    task automatic t_srq();
        for (int i = 0; i < 4; i++) begin
            host.send(SWR, 2'h0, 16'(i));
            host.query(SRD, 2'h0, d);
            check("srq code", d, 8'(i));
        end
        host.send(SWR, 2'h0, 16'h0001);
        host.send(EWR, 2'h2, 16'h0040);
        cond_pins[22] = 1'b1;
        idle(5);
        check("srq on fault", {6'h0, srq_lamp, srq_line}, 8'h03);
        host.service(d, lv);
        check("polled byte", d, 8'h54);
        check("latch after poll", lv, 8'h40);
        idle(5);
        check("no repeat srq", {7'h0, srq_line}, 8'h00);
        err_pulse();
        check("error not enabled", {7'h0, srq_line}, 8'h00);
        poll_is("error flag", 8'h30);
        host.send(EQ, 2'h0, 16'h0000);
        host.send(SWR, 2'h0, 16'h0002);
        err_pulse();
        check("srq on error", {7'h0, srq_line}, 8'h01);
        poll_is("error request", 8'h70);
        host.send(EQ, 2'h0, 16'h0000);
        poll_is("error queried", 8'h10);
        host.send(SWR, 2'h0, 16'h0000);
        $display("service request test done");
    endtask
    task automatic t_absent();
        host.send(EWR, 2'h3, 16'h00ff);
        cond_pins[31:24] = 8'hff;
        idle(5);
        poll_is("absent output", 8'h10);
        $display("absent output test done");
    endtask
    task automatic t_dropout();
        host.send(PWR, 2'h0, 16'h0001);
        line_dropout = 1'b1;
        idle(5);
        check("srq on dropout", {7'h0, srq_line}, 8'h01);
        poll_is("dropout poll", 8'hd0);
        line_dropout = 1'b0;
        host.send(PWR, 2'h0, 16'h0000);
        line_dropout = 1'b1;
        idle(5);
        check("dropout not enabled", {7'h0, srq_line}, 8'h00);
        poll_is("power-up flag set", 8'h90);
        line_dropout = 1'b0;
        host.send(CLR, 2'h0, 16'h0000);
        poll_is("power-up flag cleared", 8'h10);
        $display("dropout test done");
    endtask
    task automatic t_ready();
        cmd_busy = 1'b1;
        idle(3);
        poll_is("busy", 8'h00);
        cmd_busy = 1'b0;
        idle(3);
        poll_is("ready", 8'h10);
        $display("ready test done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        idle(4);
        nrst = 1'b1;
        t_powerup();
        t_latch();
        t_mask_edge();
        t_reprog();
        t_srq();
        t_absent();
        t_dropout();
        t_ready();
        report_and_stop();
    end
    // watchdog well beyond the two hundred or so cycles the tests take
    initial begin
        idle(3000);
        fails++;
        report_and_stop();
    end
endmodule
